// ---- overlay_pkg.sv ----
// constants shared by the cursor, caret and pointer overlay
// assumes an indexed extension port and a dot-clock pixel stream
package overlay_pkg;
  // index of the attribute register behind the extension data port
  localparam logic [7:0] ATTR_INDEX = 8'hA5;
  localparam logic [7:0] ATTR_RESET = 8'h00;
  // attribute bit positions
  localparam int BIT_PTR_EN = 7;
  localparam int BIT_CARET_EN = 6;
  localparam int BIT_CARET_WHITE = 5;
  localparam int BIT_CARET_INV = 4;
  localparam int BIT_CURSOR_INV = 3;
  localparam int BIT_SLOW = 2;
  localparam int BIT_CARET_STEADY = 1;
  localparam int BIT_CURSOR_STEADY = 0;
  // fixed caret colour codes
  localparam logic [3:0] CARET_BLACK = 4'h0;
  localparam logic [3:0] CARET_WHITE = 4'hF;
  // display memory segments of the mask patterns
  localparam logic [3:0] SEG_A = 4'hA;
  localparam logic [3:0] SEG_B = 4'hB;
  // pointer pattern geometry: 32x32, two masks of 128 bytes
  localparam int PTR_SIZE = 32;
  localparam int MASK_BYTES = 128;
  localparam int FETCH_BYTES = 256;
  // retrace counter bits that carry the blink phases (8 and 16 retraces)
  localparam int FAST_BIT = 3;
  localparam int SLOW_BIT = 4;
  // legacy cursor function codes from start-row bits 6-5
  localparam logic [1:0] LEG_FAST = 2'b00;
  localparam logic [1:0] LEG_NONE_A = 2'b01;
  localparam logic [1:0] LEG_NONE_B = 2'b10;
  localparam logic [1:0] LEG_SLOW = 2'b11;
  localparam int LEG_CODE_LSB = 5;
endpackage

// ---- pixel_skid_buffer.sv ----
// two-entry pixel buffer between the pointer merge and the video sink
// assumes one clock; a sink stall fills it and drops in_ready
`timescale 1ns/10ps
`default_nettype none
module pixel_skid_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] tail_r; // second entry, used only when full
  logic [1:0] count_r; // entries held
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////
  // head, tail and count; head always drives out_data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 2'd0;
      out_data <= '0;
      tail_r <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      unique case (count_r)
        2'd0: begin
          if (push) begin
            out_data <= in_data;
            count_r <= 2'd1;
          end
        end
        2'd1: begin
          if (push && pop) begin
            out_data <= in_data;
          end else if (push) begin
            tail_r <= in_data;
            count_r <= 2'd2;
          end else if (pop) begin
            count_r <= 2'd0;
          end
        end
        default: begin
          // full: no push can happen, in_ready is low
          if (pop) begin
            out_data <= tail_r;
            count_r <= 2'd1;
          end
        end
      endcase
      // flags registered from the next count so ports come from flops
      if (count_r == 2'd0) begin
        out_valid <= push;
        in_ready <= 1'b1;
      end else if (count_r == 2'd1) begin
        out_valid <= push || !pop;
        in_ready <= !(push && !pop);
      end else begin
        out_valid <= 1'b1;
        in_ready <= pop;
      end
    end
  end
endmodule
`default_nettype wire

// ---- cursor_caret_pointer_overlay.sv ----
// overlay of text cursor, caret and 32x32 mouse pointer on the pixel stream
// assumes the rest of the controller supplies positions, rows and mode
// flags as levels, a one-cycle vertical retrace pulse, and a byte-wide
// display memory read port answering with an acknowledge
//
// Overview of operation
// [R1] bit 7 shows the 32x32 pointer
// [R2] screen mask: 128 bytes at Ann00/Bnn00
// [R3] pointer mask: 128 bytes at Ann80
// [R4] pixel AND screen mask, XOR pointer mask
// [R5] no pointer or caret in legacy modes
// [R6] bit 6 shows sized, positioned caret
// [R7] text cursor only in text mode, rows
// [R8] caret inserted before the palette lookup
// [R9] caret shifted by scroll and panning
// [R10] bit 5 picks black or white caret
// [R11] bit 4 picks fixed or inverted caret
// [R12] bit 3 picks foreground or reverse cursor
// [R13] bit 2 picks fast or slow blink
// [R14] blink 8/8 or 16/16 vertical retraces
// [R15] bit 1 holds the caret steady
// [R16] bit 0 holds the enhanced cursor steady
// [R17] legacy cursor from start-row bits 6-5
// [R18] attribute cleared by reset, sync reset
// [R19] legacy code 10 none, 11 slow
// [R20] blink phases from free retrace count
// [R21] pointer at 11-bit x, 10-bit y
// [R22] new pointer x taken at retrace only
// [R23] caret y is 2+8 bit scan line
`timescale 1ns/10ps
`default_nettype none
module cursor_caret_pointer_overlay #(
  parameter bit SYNC_RESET_CLEARS = 1'b1, // revision D behaviour
  parameter int PIX_W = 8 // width of palette output pixels
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic seq_sync_reset,
  input wire logic io_index_wr,
  input wire logic io_data_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic legacy_compat_modes,
  input wire logic text_mode,
  input wire logic vretrace,
  input wire logic [2:0] pointer_x_upper,
  input wire logic [7:0] pointer_x_lower,
  input wire logic [1:0] pointer_y_upper,
  input wire logic [7:0] pointer_y_lower,
  input wire logic [7:0] pointer_pattern_page,
  input wire logic pattern_seg_b,
  input wire logic [7:0] caret_height,
  input wire logic [7:0] caret_width,
  input wire logic [2:0] caret_x_upper,
  input wire logic [7:0] caret_x_lower,
  input wire logic [1:0] caret_y_upper,
  input wire logic [7:0] caret_y_lower,
  input wire logic [4:0] smooth_scroll,
  input wire logic [2:0] pixel_pan,
  input wire logic [7:0] cursor_start_row,
  input wire logic [4:0] cursor_end_row,
  input wire logic cursor_cell,
  input wire logic [4:0] char_row,
  input wire logic [3:0] fg_color,
  input wire logic pre_valid,
  input wire logic [3:0] pre_pixel,
  input wire logic [10:0] pre_x,
  input wire logic [9:0] pre_y,
  output logic pal_valid,
  output logic [3:0] pal_pixel,
  input wire logic post_valid,
  output logic post_ready,
  input wire logic [PIX_W-1:0] post_pixel,
  input wire logic [10:0] post_x,
  input wire logic [9:0] post_y,
  output logic video_valid,
  input wire logic video_ready,
  output logic [PIX_W-1:0] video_pixel,
  output logic mem_req,
  output logic [19:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  typedef enum logic [1:0] {FETCH_IDLE, FETCH_REQ, FETCH_DONE} fetch_t;

  logic [7:0] index_r; // extension index latch
  logic [7:0] attr_r; // overlay_attribute_control
  logic [4:0] retrace_cnt_r; // free-running count of retraces
  logic [10:0] ptr_x_active_r; // pointer x, moved at retrace only
  logic [7:0] mask_mem [0:overlay_pkg::FETCH_BYTES-1]; // screen then pointer mask
  fetch_t fetch_r;
  logic [7:0] fetch_idx_r; // byte being fetched
  logic [7:0] page_r; // page latched for the whole fetch
  logic seg_b_r; // segment latched for the whole fetch
  logic mask_valid_r; // at least one complete fetch held
  logic blink_fast;
  logic blink_slow;
  logic blink_on;
  logic ptr_en;
  logic caret_en;
  logic caret_on;
  logic cursor_on;
  logic [3:0] pal_nxt;
  logic [11:0] caret_x_eff;
  logic [10:0] caret_y_eff;
  logic [11:0] caret_dx;
  logic [10:0] caret_dy;
  logic [11:0] ptr_dx;
  logic [10:0] ptr_dy;
  logic ptr_hit;
  logic [2:0] bit_sel;
  logic [6:0] byte_sel;
  logic scr_bit;
  logic ptr_bit;
  logic [PIX_W-1:0] merged;
  logic [1:0] leg_code;
  logic row_in;
  logic cursor_blink_ok;

  ////////////////////////////////////////////////////////////////////////
  // indexed register port

  // index latch; written through the index port
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      index_r <= 8'h00;
    end else if (io_index_wr) begin
      index_r <= io_wdata;
    end
  end

  // attribute register; sync reset clear chosen by parameter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      attr_r <= overlay_pkg::ATTR_RESET; // [R18]
    end else if (SYNC_RESET_CLEARS && seq_sync_reset) begin
      attr_r <= overlay_pkg::ATTR_RESET; // [R18]
    end else if (io_data_wr && index_r == overlay_pkg::ATTR_INDEX) begin
      attr_r <= io_wdata;
    end
  end

  // read data registered; other indices belong to other blocks
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
    end else if (index_r == overlay_pkg::ATTR_INDEX) begin
      io_rdata <= attr_r;
    end else begin
      io_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // blink timing

  // free-running retrace count; cursor and caret share it so they stay in step
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      retrace_cnt_r <= 5'd0;
    end else if (vretrace) begin
      retrace_cnt_r <= retrace_cnt_r + 5'd1; // [R20]
    end
  end

  // low half of each period is off, high half on
  assign blink_fast = retrace_cnt_r[overlay_pkg::FAST_BIT]; // [R14]
  assign blink_slow = retrace_cnt_r[overlay_pkg::SLOW_BIT]; // [R14]
  assign blink_on = attr_r[overlay_pkg::BIT_SLOW] ? blink_slow : blink_fast; // [R13]

  ////////////////////////////////////////////////////////////////////////
  // caret and cursor, ahead of the palette

  // neither overlay exists in the legacy modes
  assign ptr_en = attr_r[overlay_pkg::BIT_PTR_EN] && !legacy_compat_modes; // [R1] [R5]
  assign caret_en = attr_r[overlay_pkg::BIT_CARET_EN] && !legacy_compat_modes; // [R6] [R5]

  // caret origin moved by panning and smooth scroll
  assign caret_x_eff = {1'b0, caret_x_upper, caret_x_lower} + {9'd0, pixel_pan}; // [R9]
  assign caret_y_eff = {1'b0, caret_y_upper, caret_y_lower} + {6'd0, smooth_scroll}; // [R9] [R23]
  assign caret_dx = {1'b0, pre_x} - caret_x_eff;
  assign caret_dy = {1'b0, pre_y} - caret_y_eff;

  // inside the box when the unsigned offset is below the size
  assign caret_on = caret_en && caret_dx < {4'd0, caret_width} // [R6]
    && caret_dy < {3'd0, caret_height}
    && (attr_r[overlay_pkg::BIT_CARET_STEADY] || blink_on); // [R15]

  // cursor rows; start/end held to 32 scan rows
  assign row_in = char_row >= cursor_start_row[4:0] && char_row <= cursor_end_row; // [R7]
  assign leg_code = cursor_start_row[overlay_pkg::LEG_CODE_LSB +: 2];

  // legacy modes ignore the attribute register for the cursor
  always_comb begin
    cursor_blink_ok = 1'b0;
    if (legacy_compat_modes) begin
      unique case (leg_code)
        overlay_pkg::LEG_FAST: cursor_blink_ok = blink_fast; // [R17]
        overlay_pkg::LEG_NONE_A: cursor_blink_ok = 1'b0; // [R17]
        overlay_pkg::LEG_NONE_B: cursor_blink_ok = 1'b0; // [R19]
        overlay_pkg::LEG_SLOW: cursor_blink_ok = blink_slow; // [R19]
      endcase
    end else begin
      cursor_blink_ok = attr_r[overlay_pkg::BIT_CURSOR_STEADY] || blink_on; // [R16]
    end
  end

  assign cursor_on = text_mode && cursor_cell && row_in && cursor_blink_ok; // [R7]

  // caret wins over cursor where both fall on a pixel
  always_comb begin
    pal_nxt = pre_pixel;
    if (caret_on) begin
      if (attr_r[overlay_pkg::BIT_CARET_INV]) begin
        pal_nxt = ~pre_pixel; // [R11]
      end else if (attr_r[overlay_pkg::BIT_CARET_WHITE]) begin
        pal_nxt = overlay_pkg::CARET_WHITE; // [R10]
      end else begin
        pal_nxt = overlay_pkg::CARET_BLACK; // [R10]
      end
    end else if (cursor_on) begin
      // legacy cursor is always the plain foreground block
      if (attr_r[overlay_pkg::BIT_CURSOR_INV] && !legacy_compat_modes) begin
        pal_nxt = ~pre_pixel; // [R12]
      end else begin
        pal_nxt = fg_color; // [R12]
      end
    end
  end

  // registered stage into the palette; caret colour is then translated
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pal_valid <= 1'b0;
      pal_pixel <= 4'h0;
    end else begin
      pal_valid <= pre_valid;
      pal_pixel <= pal_nxt; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer position and mask fetch

  // moving x mid-frame would tear the pointer, so it waits for retrace
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ptr_x_active_r <= 11'd0;
    end else if (vretrace) begin
      ptr_x_active_r <= {pointer_x_upper, pointer_x_lower}; // [R22] [R21]
    end
  end

  // fetch of both masks, started at each retrace while the pointer is on
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fetch_r <= FETCH_IDLE;
      fetch_idx_r <= 8'd0;
      page_r <= 8'h00;
      seg_b_r <= 1'b0;
      mask_valid_r <= 1'b0;
    end else begin
      unique case (fetch_r)
        FETCH_IDLE: begin
          if (vretrace && ptr_en) begin
            fetch_r <= FETCH_REQ;
            fetch_idx_r <= 8'd0;
            page_r <= pointer_pattern_page;
            seg_b_r <= pattern_seg_b;
          end
        end
        FETCH_REQ: begin
          if (mem_ack) begin
            fetch_idx_r <= fetch_idx_r + 8'd1;
            if (fetch_idx_r == 8'(overlay_pkg::FETCH_BYTES - 1)) begin
              fetch_r <= FETCH_DONE;
            end
          end
        end
        FETCH_DONE: begin
          mask_valid_r <= 1'b1;
          fetch_r <= FETCH_IDLE;
        end
        default: fetch_r <= FETCH_IDLE;
      endcase
    end
  end

  // mask store; byte order follows the display memory order
  always_ff @(posedge clock) begin
    if (fetch_r == FETCH_REQ && mem_ack) begin
      mask_mem[fetch_idx_r] <= mem_rdata;
    end
  end

  // read request; address for the next byte prepared with the request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_req <= 1'b0;
      mem_addr <= 20'h0_0000;
    end else begin
      mem_req <= (fetch_r == FETCH_IDLE && vretrace && ptr_en)
        || (fetch_r == FETCH_REQ && !(mem_ack
        && fetch_idx_r == 8'(overlay_pkg::FETCH_BYTES - 1)));
      if (fetch_r == FETCH_IDLE) begin
        mem_addr <= {pattern_seg_b ? overlay_pkg::SEG_B : overlay_pkg::SEG_A,
          pointer_pattern_page, 8'h00}; // [R2]
      end else if (fetch_r == FETCH_REQ && mem_ack) begin
        if (fetch_idx_r < 8'(overlay_pkg::MASK_BYTES - 1)) begin
          mem_addr <= {seg_b_r ? overlay_pkg::SEG_B : overlay_pkg::SEG_A,
            page_r, 1'b0, 7'(fetch_idx_r + 8'd1)}; // [R2]
        end else begin
          // pointer mask lives in segment A only
          mem_addr <= {overlay_pkg::SEG_A, page_r, 1'b1, 7'(fetch_idx_r + 8'd1)}; // [R3]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer merge at the palette output

  assign ptr_dx = {1'b0, post_x} - {1'b0, ptr_x_active_r}; // [R21]
  assign ptr_dy = {1'b0, post_y} - {1'b0, pointer_y_upper, pointer_y_lower}; // [R21]
  assign ptr_hit = ptr_en && mask_valid_r && ptr_dx < 12'(overlay_pkg::PTR_SIZE)
    && ptr_dy < 11'(overlay_pkg::PTR_SIZE); // [R1]
  // four bytes per row, left pixel in the top bit
  assign byte_sel = {ptr_dy[4:0], ptr_dx[4:3]};
  assign bit_sel = 3'd7 - ptr_dx[2:0];
  assign scr_bit = mask_mem[{1'b0, byte_sel}][bit_sel];
  assign ptr_bit = mask_mem[{1'b1, byte_sel}][bit_sel];

  // 00 black, 01 white, 10 pixel, 11 inverted
  assign merged = ptr_hit ? ((post_pixel & {PIX_W{scr_bit}}) ^ {PIX_W{ptr_bit}})
    : post_pixel; // [R4]

  pixel_skid_buffer #(
    .WIDTH(PIX_W)
  ) out_buffer (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(post_valid),
    .in_ready(post_ready),
    .in_data(merged),
    .out_valid(video_valid),
    .out_ready(video_ready),
    .out_data(video_pixel)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_sync_clear;
    SYNC_RESET_CLEARS && seq_sync_reset;
  endsequence

  sync_reset_clear_a: assert property (s_sync_clear |=> attr_r == 8'h00) // [R18]
    else $error("attribute not cleared by sync reset");
  pointer_off_a: assert property (!attr_r[7] |-> !ptr_hit) // [R1]
    else $error("pointer drawn while disabled");
  legacy_hidden_a: assert property (legacy_compat_modes |-> !caret_on && !ptr_hit) // [R5]
    else $error("overlay shown in legacy mode");
  caret_colour_a: assert property (pre_valid && caret_on && !attr_r[4]
    |=> pal_pixel == ($past(attr_r[5]) ? 4'hF : 4'h0)) // [R10]
    else $error("caret colour wrong");
  blink_step_a: assert property (!vretrace |=> $stable(blink_fast) && $stable(blink_slow)) // [R14]
    else $error("blink phase moved without retrace");
  ptr_x_hold_a: assert property (!vretrace |=> $stable(ptr_x_active_r)) // [R22]
    else $error("pointer x moved mid frame");
  fetch_page_a: assert property (mem_req && fetch_r == FETCH_REQ
    |-> mem_addr[15:8] == page_r && (mem_addr[7] || mem_addr[19:16] != 4'h0)) // [R2]
    else $error("mask fetch outside pattern page");
  mask_black_a: assert property (post_valid && post_ready && ptr_hit && !scr_bit && !ptr_bit
    |-> merged == '0) // [R4]
    else $error("pointer black pixel wrong");
  legacy_none_a: assert property (legacy_compat_modes && leg_code[0] != leg_code[1]
    |-> !cursor_on) // [R17]
    else $error("legacy cursor shown for no-cursor code");
endmodule
`default_nettype wire

// ---- mask_memory_model.sv ----
// display memory model answering the overlay's pointer mask fetches
// assumes mem_req and mem_addr are held until acknowledged, one byte per ack
`timescale 1ns/10ps
`default_nettype none
module mask_memory_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic seg_b,
  input wire logic [7:0] page,
  input wire logic mem_req,
  input wire logic [19:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  output logic [9:0] ack_count,
  output logic addr_err
);
  logic [1:0] wait_r; // idle cycles spent on this request
  logic [3:0] seg; // segment the next byte must come from
  ////////////////////////////////////////////////////////////////////////////////
  // screen half may sit in segment b, pointer half is always in segment a
  assign seg = (ack_count[7] || !seg_b) ? overlay_pkg::SEG_A : overlay_pkg::SEG_B;
  // answer after 0 or 2 idle cycles; idle bus toggles so no stale byte looks valid
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h5A;
      wait_r <= 2'h0;
      ack_count <= 10'h000;
      addr_err <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && wait_r == {slow, 1'b0}) begin
        mem_ack <= 1'b1;
        // pointer mask bytes : screen mask bytes
        mem_rdata <= mem_addr[7] ? 8'hAA : 8'hCC;
        ack_count <= ack_count + 10'h001;
        wait_r <= 2'h0;
        if (mem_addr !== {seg, page, ack_count[7:0]}) addr_err <= 1'b1;
      end else if (mem_req && !mem_ack) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_cursor_caret_pointer_overlay.sv ----
// self-checking bench for the cursor, caret and pointer overlay
// assumes the mask memory model on the fetch port; palette output driven here
`timescale 1ns/10ps
`default_nettype none
module tb_cursor_caret_pointer_overlay;
  logic clock, reset_n, seq_sync_reset, io_index_wr, io_data_wr, legacy, text_mode, vretrace;
  logic seg_b, pre_valid, pal_valid, post_valid, post_ready, video_valid, video_ready;
  logic mem_req, mem_ack, slow, cursor_cell, addr_err;
  logic [7:0] io_wdata, io_rdata, px_lo, page, start_row, post_pixel, video_pixel, mem_rdata;
  logic [7:0] csize, cx, cy;
  logic [10:0] pre_x, post_x;
  logic [9:0] pre_y, post_y, ack_count;
  logic [4:0] scroll, char_row, er;
  logic [2:0] pan;
  logic [3:0] fg, pre_pixel, pal_pixel;
  logic [19:0] mem_addr;
  logic [7:0] attr_tab [4] = '{8'h62, 8'h42, 8'h52, 8'h02}; // caret attribute cases
  logic [3:0] car_tab [4] = '{4'hF, 4'h0, 4'hA, 4'h5}; // pixel seen for each case
  int errors = 0, checks = 0, cycles = 0, vcount = 0;
  ////////////////////////////////////////////////////////////////////////////////
  cursor_caret_pointer_overlay dut_u (
    .clock(clock), .reset_n(reset_n), .seq_sync_reset(seq_sync_reset),
    .io_index_wr(io_index_wr), .io_data_wr(io_data_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .legacy_compat_modes(legacy), .text_mode(text_mode), .vretrace(vretrace),
    .pointer_x_upper(3'h0), .pointer_x_lower(px_lo), .pointer_y_upper(2'h0),
    .pointer_y_lower(8'h00), .pointer_pattern_page(page), .pattern_seg_b(seg_b),
    .caret_height(csize), .caret_width(csize), .caret_x_upper(3'h0), .caret_x_lower(cx),
    .caret_y_upper(2'h0), .caret_y_lower(cy), .smooth_scroll(scroll), .pixel_pan(pan),
    .cursor_start_row(start_row), .cursor_end_row(er), .cursor_cell(cursor_cell),
    .char_row(char_row), .fg_color(fg), .pre_valid(pre_valid), .pre_pixel(pre_pixel),
    .pre_x(pre_x), .pre_y(pre_y), .pal_valid(pal_valid), .pal_pixel(pal_pixel),
    .post_valid(post_valid), .post_ready(post_ready), .post_pixel(post_pixel),
    .post_x(post_x), .post_y(post_y), .video_valid(video_valid), .video_ready(video_ready),
    .video_pixel(video_pixel), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  mask_memory_model mem_u (
    .clock(clock), .reset_n(reset_n), .slow(slow), .seg_b(seg_b), .page(page),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ack_count(ack_count), .addr_err(addr_err));
  ////////////////////////////////////////////////////////////////////////////////
  // dot clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard: whole run needs a few thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // index write, then data write on the next cycle
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(negedge clock);
    io_index_wr = 1'b1;
    io_wdata = idx;
    @(negedge clock);
    io_index_wr = 1'b0;
    io_data_wr = 1'b1;
    io_wdata = data;
    @(negedge clock);
    io_data_wr = 1'b0;
  endtask
  // read back lags the index write by one clock
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clock);
    io_index_wr = 1'b1;
    io_wdata = idx;
    @(negedge clock);
    io_index_wr = 1'b0;
    @(negedge clock);
    chk("io_rdata", exp, io_rdata);
  endtask
  task automatic vr();
    @(negedge clock);
    vretrace = 1'b1;
    @(negedge clock);
    vretrace = 1'b0;
    vcount++;
  endtask
  // one pre-palette pixel, result one clock later
  task automatic pre(input logic [10:0] x, input logic [9:0] y, input logic [3:0] p,
                     input logic [3:0] exp);
    @(negedge clock);
    pre_valid = 1'b1;
    pre_x = x;
    pre_y = y;
    pre_pixel = p;
    @(negedge clock);
    pre_valid = 1'b0;
    chk("pal_pixel", {3'b000, 1'b1, exp}, {3'b000, pal_valid, pal_pixel});
  endtask
  // offer one palette pixel, held until the buffer takes it
  task automatic post(input logic [10:0] x, input logic [9:0] y, input logic [7:0] p);
    int k = 0;
    @(negedge clock);
    post_valid = 1'b1;
    post_x = x;
    post_y = y;
    post_pixel = p;
    while (post_ready !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    post_valid = 1'b0;
  endtask
  task automatic vid(input logic [7:0] exp);
    int k = 0;
    while (video_valid !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    chk("video_pixel", exp, (video_valid === 1'b1) ? video_pixel : ~exp);
  endtask
  task automatic wait_acks(input logic [9:0] n);
    int k = 0;
    while (ack_count !== n && k < 4000) begin
      @(negedge clock);
      k++;
    end
    chk("fetch_done", 8'h01, {7'h00, ack_count === n});
    repeat (3) @(negedge clock);
  endtask
  // mask bytes cc/aa give invert, keep, white, black in turn
  function automatic logic [7:0] pexp(input int x, input logic [7:0] p);
    case (x % 4)
      0: return ~p;
      1: return p;
      2: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {seq_sync_reset, io_index_wr, io_data_wr, legacy, text_mode, vretrace, seg_b} = '0;
    {pre_valid, post_valid, slow, cursor_cell, reset_n} = '0;
    {io_wdata, px_lo, page, start_row, post_pixel, cx, cy, pre_x, post_x, pre_y, post_y} = '0;
    {scroll, char_row, pan, fg, pre_pixel} = '0;
    {video_ready, csize, er} = {1'b1, 8'h02, 5'h04};
    repeat (10) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    rd(8'hA5, 8'h00);
    wr(8'h94, 8'h77);
    rd(8'h94, 8'h00);
    rd(8'hA5, 8'h00);
    wr(8'hA5, 8'h5A);
    rd(8'hA5, 8'h5A);
    // blink phases of the caret, fast then slow
    wr(8'hA5, 8'h60);
    for (int i = 0; i < 20; i++) begin
      vr();
      pre(0, 0, 4'h5, vcount[3] ? 4'hF : 4'h5);
    end
    wr(8'hA5, 8'h64);
    for (int i = 0; i < 20; i++) begin
      vr();
      pre(0, 0, 4'h5, vcount[4] ? 4'hF : 4'h5);
    end
    // steady caret in every colour and mode
    for (int i = 0; i < 4; i++) begin
      wr(8'hA5, attr_tab[i]);
      pre(0, 0, 4'h5, car_tab[i]);
    end
    wr(8'hA5, 8'h62);
    pre(2, 0, 4'h5, 4'h5);
    legacy = 1'b1;
    pre(0, 0, 4'h5, 4'h5);
    legacy = 1'b0;
    text_mode = 1'b1;
    pre(0, 0, 4'h5, 4'hF);
    text_mode = 1'b0;
    {cx, cy, pan, scroll} = {8'h04, 8'h01, 3'h3, 5'h02};
    pre(7, 3, 4'h5, 4'hF);
    pre(6, 3, 4'h5, 4'h5);
    pre(7, 2, 4'h5, 4'h5);
    csize = 8'h00;
    pre(7, 3, 4'h5, 4'h5);
    {cx, cy, pan, scroll, csize} = {8'h00, 8'h00, 3'h0, 5'h00, 8'h02};
    // text cursor, rows 2 to 4 inclusive
    wr(8'hA5, 8'h01);
    {text_mode, cursor_cell, start_row, fg, char_row} = {2'b11, 8'h02, 4'h9, 5'h04};
    pre(0, 0, 4'h5, 4'h9);
    char_row = 5'h05;
    pre(0, 0, 4'h5, 4'h5);
    char_row = 5'h01;
    pre(0, 0, 4'h5, 4'h5);
    char_row = 5'h03;
    text_mode = 1'b0;
    pre(0, 0, 4'h5, 4'h5);
    text_mode = 1'b1;
    wr(8'hA5, 8'h00);
    pre(0, 0, 4'h5, vcount[3] ? 4'h9 : 4'h5);
    // legacy codes ignore the attribute, even a steady inverted cursor
    wr(8'hA5, 8'h09);
    pre(0, 0, 4'h5, 4'hA);
    legacy = 1'b1;
    for (int c = 0; c < 4; c++) begin
      start_row = {1'b0, c[1:0], 5'h02};
      pre(0, 0, 4'h5, ((c == 0) ? vcount[3] : (c == 3) ? vcount[4] : 1'b0) ? 4'h9 : 4'h5);
    end
    {legacy, text_mode, cursor_cell} = 3'b000;
    // pointer fetch from segment b page 3c, then merge
    {seg_b, page} = {1'b1, 8'h3C};
    wr(8'hA5, 8'h80);
    vr();
    wait_acks(10'h100);
    chk("addr_err", 8'h00, {7'h00, addr_err});
    for (int x = 0; x < 4; x++) begin
      post(x[10:0], 10'h000, 8'h3C);
      vid(pexp(x, 8'h3C));
    end
    post(0, 10'h028, 8'h3C);
    vid(8'h3C);
    // let the last pixel drain, then stall: two held, third refused
    @(negedge clock);
    video_ready = 1'b0;
    post(0, 10'h028, 8'h11);
    post(0, 10'h028, 8'h22);
    chk("post_ready", 8'h00, {7'h00, post_ready});
    video_ready = 1'b1;
    vid(8'h11);
    @(negedge clock);
    vid(8'h22);
    // new x waits for retrace
    px_lo = 8'h64;
    post(0, 0, 8'h3C);
    vid(8'hC3);
    slow = 1'b1;
    vr();
    wait_acks(10'h200);
    post(100, 0, 8'h3C);
    vid(8'hC3);
    post(0, 0, 8'h3C);
    vid(8'h3C);
    wr(8'hA5, 8'h00);
    post(100, 0, 8'h3C);
    vid(8'h3C);
    chk("addr_err", 8'h00, {7'h00, addr_err});
    // sequencer synchronous reset clears the attribute
    wr(8'hA5, 8'h3C);
    rd(8'hA5, 8'h3C);
    @(negedge clock);
    seq_sync_reset = 1'b1;
    @(negedge clock);
    seq_sync_reset = 1'b0;
    rd(8'hA5, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
